// file: logic/rcpc_cfg.svh
// Offsets, field positions, reset values and timing counts of the reset configuration capture
`ifndef RCPC_CFG_SVH
`define RCPC_CFG_SVH

// Register byte offsets on the APB
`define RCPC_OFS_STATUS       12'h000
`define RCPC_OFS_CTRL         12'h004

// Status register fields
`define RCPC_ST_BOOT_BIT      0
`define RCPC_ST_PULL_BIT      1
`define RCPC_ST_DBG_BIT       2
`define RCPC_ST_OSC_BIT       3
`define RCPC_ST_SRC_LSB       8
`define RCPC_ST_SRC_MSB       11

// Control register fields (write one to trigger)
`define RCPC_CT_SWSYS_BIT     0
`define RCPC_CT_SWEXT_BIT     1

// Reset source flag positions inside the source field
`define RCPC_SRC_EXT          0
`define RCPC_SRC_SWSYS        1
`define RCPC_SRC_SWEXT        2
`define RCPC_SRC_DBG          3

// Timing: external pin filter, pull capture lead and reset output hold
`define RCPC_EXT_FILT_CYC     10
`define RCPC_PULL_LEAD_CYC    4
`define RCPC_HOLD_CYC         32

// Reset values
`define RCPC_RST_PULL         1'h0
`define RCPC_RST_BOOT         1'h0
`define RCPC_RST_DBG          1'h0

`endif

// file: logic/rcpc_pkg.sv
// Types shared by the reset configuration capture block
package rcpc_pkg;

  // Sequencer state
  typedef enum logic [1:0] {
    RCPC_RUN    = 2'b00,
    RCPC_ASSERT = 2'b01
  } rcpc_state_e;

  // Boot mode decoded from the boot select level
  typedef enum logic {
    RCPC_BOOT_FLASH  = 1'b0,
    RCPC_BOOT_SERIAL = 1'b1
  } rcpc_boot_e;

  // Synchronised pin group
  typedef struct packed {
    logic osc_stable;
    logic debug_reset_req;
    logic debug_event_input;
    logic pull_select_pin;
    logic boot_select_pin;
    logic reset_in_n;
  } rcpc_pins_s;

  // Captured configuration
  typedef struct packed {
    logic [3:0] src;
    logic       osc_ok;
    logic       debug_en;
    logic       pull_up;
    rcpc_boot_e boot;
  } rcpc_status_s;

endpackage : rcpc_pkg

// file: logic/rcpc_sync.sv
// Two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/100ps
module rcpc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_reg  <= RST_VAL[i];
          q_sync[i] <= RST_VAL[i];
        end else begin
          meta_reg  <= d_async[i];
          q_sync[i] <= meta_reg;
        end
      end
    end
  endgenerate

endmodule : rcpc_sync

// file: logic/rcpc_top.sv
// Reset configuration pin capture: reset sequencer, strap capture and APB status
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "rcpc_cfg.svh"
module rcpc_top #(
  parameter int AW       = 12,
  parameter int HOLD_CYC = `RCPC_HOLD_CYC
) (
  // Clock and power-on reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Board pins and oscillator status
  input  wire logic          reset_in_n,
  input  wire logic          boot_select_pin,
  input  wire logic          pull_select_pin,
  input  wire logic          debug_event_input,
  input  wire logic          debug_reset_req,
  input  wire logic          osc_stable,
  // Reset and configuration outputs
  output logic               reset_output_n,
  output logic               internal_reset,
  output logic               timer_pull_up,
  output logic               debug_port_en,
  output logic               boot_serial,
  output logic               trace_data_out0
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  rcpc_pkg::rcpc_pins_s pins_async;
  rcpc_pkg::rcpc_pins_s pins;

  assign pins_async = '{osc_stable:        osc_stable,
                        debug_reset_req:   debug_reset_req,
                        debug_event_input: debug_event_input,
                        pull_select_pin:   pull_select_pin,
                        boot_select_pin:   boot_select_pin,
                        reset_in_n:        reset_in_n};

  // Reset pin idles high so the synchroniser must not look like a held reset
  rcpc_sync #(
    .W       (6),
    .RST_VAL (6'h01)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d_async (pins_async),
    .q_sync  (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Constants

  localparam logic [3:0] EXT_FILT = 4'(`RCPC_EXT_FILT_CYC);
  localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);
  localparam logic [7:0] PULL_AT = 8'(HOLD_CYC - 1 - `RCPC_PULL_LEAD_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic apb_setup;
  logic apb_wr;
  logic hit_status;
  logic hit_ctrl;
  logic sw_sys_req;
  logic sw_ext_req;

  assign apb_setup  = psel & ~penable;
  assign apb_wr     = psel & penable & pready & pwrite;
  assign hit_status = (paddr == AW'(`RCPC_OFS_STATUS));
  assign hit_ctrl   = (paddr == AW'(`RCPC_OFS_CTRL));
  assign sw_sys_req = apb_wr & hit_ctrl & pwdata[`RCPC_CT_SWSYS_BIT];
  assign sw_ext_req = apb_wr & hit_ctrl & pwdata[`RCPC_CT_SWEXT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // External reset pin filter

  logic [3:0] ext_cnt_reg;
  logic       ext_req;

  // Short glitches restart the count, so only a held pin resets the chip
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_cnt_reg <= 4'h0;
    end else if (pins.reset_in_n) begin
      ext_cnt_reg <= 4'h0;
    end else if (ext_cnt_reg != EXT_FILT) begin
      ext_cnt_reg <= ext_cnt_reg + 4'h1;
    end
  end

  assign ext_req = (ext_cnt_reg == EXT_FILT);

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  rcpc_pkg::rcpc_state_e state_reg;
  logic [7:0]            cnt_reg;
  logic                  upd_reg;
  logic                  any_req;
  logic                  full_req;
  logic                  negate;

  assign full_req = ext_req | sw_sys_req;
  assign any_req  = full_req | sw_ext_req | pins.debug_reset_req;
  assign negate   = (state_reg == rcpc_pkg::RCPC_ASSERT) && (cnt_reg == HOLD_LAST);

  // Power-on reset enters the sequence at once so the straps get captured
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= rcpc_pkg::RCPC_ASSERT;
      cnt_reg   <= 8'h00;
    end else begin
      case (state_reg)
        rcpc_pkg::RCPC_RUN: begin
          if (any_req) begin
            state_reg <= rcpc_pkg::RCPC_ASSERT;
            cnt_reg   <= 8'h00;
          end
        end
        rcpc_pkg::RCPC_ASSERT: begin
          if (!pins.reset_in_n) begin
            cnt_reg <= 8'h00;
          end else if (negate) begin
            state_reg <= rcpc_pkg::RCPC_RUN;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= rcpc_pkg::RCPC_ASSERT;
          cnt_reg   <= 8'h00;
        end
      endcase
    end
  end

  // Whether this reset may refresh the pull capture and assert internal reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upd_reg <= 1'b1;
    end else if (state_reg == rcpc_pkg::RCPC_RUN && any_req) begin
      upd_reg <= full_req;
    end else if (state_reg == rcpc_pkg::RCPC_ASSERT && ext_req) begin
      upd_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reset_output_n <= 1'b0;
      internal_reset <= 1'b1;
    end else begin
      reset_output_n <= ~((state_reg == rcpc_pkg::RCPC_ASSERT) & ~negate);
      internal_reset <= (state_reg == rcpc_pkg::RCPC_ASSERT) & ~negate & upd_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture

  rcpc_pkg::rcpc_status_s st_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg.boot <= rcpc_pkg::rcpc_boot_e'(`RCPC_RST_BOOT);
    end else if (!reset_output_n) begin
      st_reg.boot <= rcpc_pkg::rcpc_boot_e'(pins.boot_select_pin);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg.pull_up <= `RCPC_RST_PULL;
    end else if (internal_reset && upd_reg && cnt_reg == PULL_AT) begin
      st_reg.pull_up <= pins.pull_select_pin;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg.debug_en <= `RCPC_RST_DBG;
    end else if (negate) begin
      st_reg.debug_en <= pins.debug_event_input;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg.osc_ok <= 1'b0;
    end else if (pins.osc_stable) begin
      st_reg.osc_ok <= 1'b1;
    end
  end

  // Source flags are sticky; a new event wins over a write-one clear
  logic [3:0] src_set;
  logic [3:0] src_clr;

  assign src_set = {pins.debug_reset_req, sw_ext_req, sw_sys_req, ext_req}
                   & {4{state_reg == rcpc_pkg::RCPC_RUN}};
  assign src_clr = (apb_wr & hit_status) ?
                   pwdata[`RCPC_ST_SRC_MSB:`RCPC_ST_SRC_LSB] : 4'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg.src <= 4'h0;
    end else begin
      st_reg.src <= (st_reg.src & ~src_clr) | src_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs

  // While internal reset is active the pads follow the pin live, up to and
  // including the latch edge, so a stale latched value never glitches out
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_pull_up <= `RCPC_RST_PULL;
    end else if (internal_reset && cnt_reg <= PULL_AT) begin
      timer_pull_up <= pins.pull_select_pin;
    end else begin
      timer_pull_up <= st_reg.pull_up;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      debug_port_en   <= `RCPC_RST_DBG;
      boot_serial     <= `RCPC_RST_BOOT;
      trace_data_out0 <= 1'b1;
    end else begin
      debug_port_en   <= st_reg.debug_en;
      boot_serial     <= (st_reg.boot == rcpc_pkg::RCPC_BOOT_SERIAL);
      trace_data_out0 <= ~st_reg.osc_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read and answer

  // Data is prepared in the setup cycle so the access phase needs no wait
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~(hit_status | hit_ctrl);
      prdata  <= 32'h0000_0000;
      if (apb_setup && !pwrite && hit_status) begin
        prdata[`RCPC_ST_BOOT_BIT]                   <= st_reg.boot;
        prdata[`RCPC_ST_PULL_BIT]                   <= st_reg.pull_up;
        prdata[`RCPC_ST_DBG_BIT]                    <= st_reg.debug_en;
        prdata[`RCPC_ST_OSC_BIT]                    <= st_reg.osc_ok;
        prdata[`RCPC_ST_SRC_MSB:`RCPC_ST_SRC_LSB] <= st_reg.src;
      end
    end
  end

endmodule : rcpc_top

// file: verification/rcpc_board.sv
// Board straps, reset switch, crystal and debug tool around the block
`timescale 1ns/100ps
module rcpc_board #(
  parameter int OSC_CYC = 40
) (
  // Clock and power-on reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Bench controls
  input  wire logic ext_low,
  input  wire logic dbg_req,
  input  wire logic boot_lvl,
  input  wire logic pull_lvl,
  input  wire logic debug_event_input_lvl,
  // Pins seen by the block
  output logic      reset_in_n,
  output logic      boot_select_pin,
  output logic      pull_select_pin,
  output logic      debug_event_input,
  output logic      debug_reset_req,
  output logic      osc_stable
);
  int osc_cnt;
  // Reset line has a pull-up, so a released switch reads high
  assign reset_in_n        = ~ext_low;
  assign boot_select_pin   = boot_lvl;
  assign pull_select_pin   = pull_lvl;
  assign debug_event_input = debug_event_input_lvl;
  assign debug_reset_req   = dbg_req;
  // Crystal needs a start-up time after power-on
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) osc_cnt <= 0;
    else if (osc_cnt < OSC_CYC) osc_cnt <= osc_cnt + 1;
  assign osc_stable = osc_cnt == OSC_CYC;
endmodule : rcpc_board

// file: verification/rcpc_chk.sv
// Port-level assertions for the reset configuration capture
`timescale 1ns/100ps
module rcpc_chk #(
  parameter int HOLD_CYC = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins and outputs
  input wire logic reset_in_n,
  input wire logic boot_select_pin,
  input wire logic osc_stable,
  input wire logic reset_output_n,
  input wire logic internal_reset,
  input wire logic timer_pull_up,
  input wire logic debug_port_en,
  input wire logic boot_serial,
  input wire logic trace_data_out0
);
  logic [3:0] low_cnt;
  logic [3:0] bs_cnt;
  logic       bs_q;
  int         out_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Raw pin low run, saturates above the filter length
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) low_cnt <= 4'h0;
    else if (reset_in_n) low_cnt <= 4'h0;
    else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) out_cnt <= 0;
    else out_cnt <= reset_output_n ? 0 : out_cnt + 1;
  // Boot pin stable run, so sync latency cannot cause false hits
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) begin
      bs_q   <= 1'b0;
      bs_cnt <= 4'h0;
    end else begin
      bs_q   <= boot_select_pin;
      bs_cnt <= (boot_select_pin != bs_q) ? 4'h0 : bs_cnt + {3'h0, bs_cnt != 4'hF};
    end
  ////////////////////////////////////////
  property p_ext;
    reset_output_n && low_cnt == 4'hA |-> ##[1:8] (!reset_output_n && internal_reset);
  endproperty
  a_ext: assert property (p_ext) else $error("pin reset not taken");
  property p_int;
    internal_reset |-> !reset_output_n;
  endproperty
  a_int: assert property (p_int) else $error("reset out high in reset");
  property p_hold;
    // Output register falls one cycle after the sequencer enters its hold
    $rose(reset_output_n) |-> out_cnt >= HOLD_CYC - 1;
  endproperty
  a_hold: assert property (p_hold) else $error("reset out too short");
  property p_pull;
    $changed(timer_pull_up) |-> !reset_output_n [*4];
  endproperty
  a_pull: assert property (p_pull) else $error("pull moved late");
  property p_boot;
    !reset_output_n && !$past(reset_output_n, 2) && bs_cnt > 4'h3 |->
      boot_serial == boot_select_pin;
  endproperty
  a_boot: assert property (p_boot) else $error("boot not copied");
  property p_bhold;
    reset_output_n && $past(reset_output_n) |-> $stable(boot_serial);
  endproperty
  a_bhold: assert property (p_bhold) else $error("boot moved in run");
  property p_dbg;
    // Enable is registered once more, so it moves one cycle after the release
    $changed(debug_port_en) |-> $past(reset_output_n) && !$past(reset_output_n, 2);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug enable moved");
  property p_trace;
    osc_stable [*5] |-> !trace_data_out0;
  endproperty
  a_trace: assert property (p_trace) else $error("trace bit stuck");
  c_soft: cover property (!reset_output_n && !internal_reset);
  c_glitch: cover property ($rose(reset_in_n) && low_cnt == 4'h5);
  c_pull: cover property ($changed(timer_pull_up));
endmodule : rcpc_chk
bind rcpc_top rcpc_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (.clk_sys, .rst, .reset_in_n,
  .boot_select_pin, .osc_stable, .reset_output_n, .internal_reset, .timer_pull_up,
  .debug_port_en, .boot_serial, .trace_data_out0);

// file: verification/rcpc_top_test.sv
// Self-checking bench for the reset configuration capture
`timescale 1ns/100ps
module rcpc_top_test;
  logic        clk_sys, rst, pready, pslverr, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        ext_low = 1'b0, dbg_req = 1'b0;
  logic        boot_lvl = 1'b1, pull_lvl = 1'b1, debug_event_input_lvl = 1'b1;
  logic        reset_in_n, boot_select_pin, pull_select_pin, debug_event_input;
  logic        debug_reset_req, osc_stable, reset_output_n, internal_reset;
  logic        timer_pull_up, debug_port_en, boot_serial, trace_data_out0;
  int          failures = 0, tests_run = 0;

  rcpc_top #(.HOLD_CYC(12)) dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .reset_in_n, .boot_select_pin, .pull_select_pin,
    .debug_event_input, .debug_reset_req, .osc_stable, .reset_output_n, .internal_reset,
    .timer_pull_up, .debug_port_en, .boot_serial, .trace_data_out0);
  rcpc_board board (.clk_sys, .rst, .ext_low, .dbg_req, .boot_lvl, .pull_lvl, .debug_event_input_lvl,
    .reset_in_n, .boot_select_pin, .pull_select_pin, .debug_event_input,
    .debug_reset_req, .osc_stable);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task automatic test_done;
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (s !== v) begin
      failures++;
      test_done();
    end
  endtask : wait_for
  // One APB transfer, released only at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    wait_for(pready, 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(trace_data_out0, 1'b1);
    wait_for(reset_output_n, 1'b1);
    // Debug enable lands one cycle after reset output rises
    @(posedge clk_sys);
    check({boot_serial, timer_pull_up, debug_port_en}, 3'h7);
    wait_for(trace_data_out0, 1'b0);
    check(osc_stable, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd[3:0], 4'hF);
    apb(1'b1, 12'h000, 32'h0000_0F00);
    // Software external reset: straps moved, pull must not follow
    {boot_lvl, pull_lvl} <= 2'h0;
    apb(1'b1, 12'h004, 32'h0000_0002);
    wait_for(reset_output_n, 1'b0);
    check(internal_reset, 1'b0);
    wait_for(reset_output_n, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_040E);
    check({boot_serial, timer_pull_up}, 2'h1);
    dbg_req <= 1'b1;
    wait_for(reset_output_n, 1'b0);
    dbg_req <= 1'b0;
    wait_for(reset_output_n, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_0C0E);
    apb(1'b1, 12'h000, 32'h0000_0F00);
    debug_event_input_lvl <= 1'b0;
    apb(1'b1, 12'h004, 32'h0000_0001);
    wait_for(internal_reset, 1'b1);
    repeat (2) @(posedge clk_sys);
    check(timer_pull_up, 1'b0);
    wait_for(reset_output_n, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_0208);
    check({timer_pull_up, debug_port_en}, 2'h0);
    // Short pin pulse must be filtered out
    ext_low <= 1'b1;
    repeat (5) @(posedge clk_sys);
    ext_low <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check(reset_output_n, 1'b1);
    {boot_lvl, pull_lvl, debug_event_input_lvl, ext_low} <= 4'hF;
    repeat (14) @(posedge clk_sys);
    ext_low <= 1'b0;
    wait_for(reset_output_n, 1'b0);
    wait_for(reset_output_n, 1'b1);
    {boot_lvl, pull_lvl, debug_event_input_lvl} <= 3'h0;
    repeat (5) @(posedge clk_sys);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_030F);
    check({boot_serial, timer_pull_up, debug_port_en}, 3'h7);
    apb(1'b0, 12'h008, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    test_done();
  end
endmodule : rcpc_top_test
